//--- rcfl_map.svh
`ifndef RCFL_MAP_SVH
`define RCFL_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RCFL_OFS_FLAGS0 8'h00
`define RCFL_OFS_FLAGS1 8'h04
`define RCFL_OFS_STATUS 8'h08
`define RCFL_OFS_EVT_STAT 8'h0C
`define RCFL_OFS_EVT_MASK 8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCFL_B_STACK_OVERFLOW_FLAG 7
`define RCFL_B_STACK_UNDERFLOW_FLAG 6
`define RCFL_B_WINVIO 5
`define RCFL_B_WDTTO 4
`define RCFL_B_EXTRST 3
`define RCFL_B_RSTINS 2
`define RCFL_B_PWRON 1
`define RCFL_B_BROWN 0
`define RCFL_B_MEMVIO 1
`define RCFL_B_TIMEOUT 1
`define RCFL_B_PWRDN 0
// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define RCFL_FLAGS0_POR 8'h3C
`define RCFL_FLAGS1_POR 8'h02
`define RCFL_FLAGS1_MASK 8'h02
`define RCFL_VEC_RESET 32'h0000_0000
`define RCFL_VEC_IRQ 32'h0000_0004
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCFL_CLK_NS 100
`define RCFL_HOLD_NS 200
`define RCFL_HOLD_CYC ((`RCFL_HOLD_NS + `RCFL_CLK_NS - 1) / `RCFL_CLK_NS)
`endif

//--- rcfl_pkg.sv
package rcfl_pkg;
   // ----------------------------------------------------------------
   // reset and wake-up source pulses
   // ----------------------------------------------------------------
   typedef struct packed {
      logic brownout;
      logic ext_reset;
      logic wdt_timeout;
      logic wdt_window;
      logic reset_instr;
      logic stack_ovf;
      logic stack_unf;
      logic mem_viol;
      logic wdt_wake;
      logic irq_wake;
   } rcfl_evt_t;

   // register access request from the bus slave
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } rcfl_req_t;

   typedef enum logic [3:0] {
      RCFL_C_NONE = 4'b0000,
      RCFL_C_BROWN = 4'b0001,
      RCFL_C_MEMORY_VIOLATION_FLAG = 4'b0010,
      RCFL_C_EXT = 4'b0011,
      RCFL_C_EXT_SLP = 4'b0100,
      RCFL_C_WDT_TO = 4'b0101,
      RCFL_C_WDT_WV = 4'b0110,
      RCFL_C_RSTINS = 4'b0111,
      RCFL_C_OVF = 4'b1000,
      RCFL_C_UNF = 4'b1001,
      RCFL_C_WDT_WAKE = 4'b1010,
      RCFL_C_IRQ_WAKE = 4'b1011
   } rcfl_cause_t;

   typedef enum logic [1:0] {
      RCFL_S_RUN = 2'b00,
      RCFL_S_HOLD = 2'b01,
      RCFL_S_WAKE = 2'b10
   } rcfl_state_t;
endpackage

//--- rcfl_ahb_slv.sv
`include "rcfl_map.svh"
module rcfl_ahb_slv (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output rcfl_pkg::rcfl_req_t req,
   input wire logic [31:0] rd_val
);
   import rcfl_pkg::*;
   logic accept;
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] addr_reg;

   // address phase taken only for whole-word nonseq/seq transfers
   assign accept = hsel && htrans[1] && hready && (hsize == 3'h2);

   // address capture and pending flags
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= accept && hwrite;
         rd_pend_reg <= accept && !hwrite;
         if (accept) begin
            addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
         end
      end
   end

   // reads take one wait state so that a preceding write is visible
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (accept && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend_reg) begin
            hrdata <= rd_val;
            hreadyout <= 1'b1;
         end
      end
   end

   // request towards the register file
   assign req.wr = wr_pend_reg;
   assign req.rd = rd_pend_reg;
   assign req.addr = addr_reg;
   assign req.wdata = hwdata;
endmodule

//--- rcfl_irq.sv
module rcfl_irq #(
   parameter int W = 10
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] set,
   input wire logic clr_wr,
   input wire logic mask_wr,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] stat,
   output logic [W-1:0] mask,
   output logic irq
);
   logic [W-1:0] stat_next;

   initial begin
      if (W < 1 || W > 32) begin
         $error("rcfl_irq: W out of range");
      end
   end

   // sticky bits, write one to clear, a new event wins over the clear
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         assign stat_next[i] = set[i] || (stat[i] && !(clr_wr && wdata[i]));
      end
   endgenerate

   // status, mask and level interrupt
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stat <= '0;
         mask <= '0;
         irq <= 1'b0;
      end else begin
         stat <= stat_next;
         if (mask_wr) begin
            mask <= wdata;
         end
         irq <= |(stat_next & (mask_wr ? wdata : mask));
      end
   end
endmodule

//--- rcfl_top.sv
// Contract
// - pin reset awake: pc zero, clear bit3, memory_violation_flag one
// - pin reset asleep: timeout set, powerdown clear
// - watchdog wake: pc+1, clear timeout and powerdown
// - interrupt wake: pc+1, timeout set, powerdown clear
// - interrupt wake with irq enable: next instruction, push, vector
// - enabled overflow reset sets bit7, pc zero
// - enabled underflow reset sets bit6
// - only the cause's own flag changes, bar brown-out (bits 7:2 inactive) and pin reset awake (flags1 bit1)
// - software may force flags, no reset results
// - power-on flag zero at power-on
// - brown-out reset clears brown-out flag
// - window violation reset clears bit5
// - watchdog timeout reset clears bit4
// - reset instruction clears bit2
// - memory violation clears memory_violation_flag, one at power-on
// - unimplemented bits read zero, writes ignored
// - stack resets only with stack reset enable
`include "rcfl_map.svh"
module rcfl_top #(
   parameter int PC_W = 16,
   parameter int HOLD_CYC = `RCFL_HOLD_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire rcfl_pkg::rcfl_evt_t evt,
   input wire logic asleep,
   input wire logic stack_reset_enable,
   input wire logic global_irq_enable,
   input wire logic [PC_W-1:0] pc_now,
   input wire logic instr_done,
   output logic cpu_hold,
   output logic pc_load,
   output logic [PC_W-1:0] pc_load_value,
   output logic ret_push,
   output logic [PC_W-1:0] ret_addr,
   output logic timeout_status_bit,
   output logic powerdown_status_bit,
   output logic irq
);
   import rcfl_pkg::*;
   localparam int EVT_W = $bits(rcfl_evt_t);

   rcfl_req_t req;
   rcfl_cause_t cause;
   rcfl_state_t state_reg;
   logic [7:0] flags0_reg;
   logic [7:0] flags1_reg;
   logic [31:0] rd_val;
   logic [EVT_W-1:0] evt_stat;
   logic [EVT_W-1:0] evt_mask;
   logic [7:0] hold_cnt_reg;
   logic is_reset;
   logic is_wake;
   logic wr_f0, wr_f1, wr_clr, wr_msk;

   initial begin
      if (PC_W < 3 || PC_W > 32 || HOLD_CYC < 1 || HOLD_CYC > 255) begin
         $error("rcfl_top: parameter out of range");
      end
   end

   // ----------------------------------------------------------------
   // bus slave and interrupt unit
   // ----------------------------------------------------------------
   rcfl_ahb_slv u_slv (
      .clk(clk),
      .arst_n(arst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .req(req),
      .rd_val(rd_val)
   );

   // write strobes per register
   assign wr_f0 = req.wr && (req.addr == `RCFL_OFS_FLAGS0);
   assign wr_f1 = req.wr && (req.addr == `RCFL_OFS_FLAGS1);
   assign wr_clr = req.wr && (req.addr == `RCFL_OFS_EVT_STAT);
   assign wr_msk = req.wr && (req.addr == `RCFL_OFS_EVT_MASK);

   rcfl_irq #(
      .W(EVT_W)
   ) u_irq (
      .clk(clk),
      .arst_n(arst_n),
      .set(evt),
      .clr_wr(wr_clr),
      .mask_wr(wr_msk),
      .wdata(req.wdata[EVT_W-1:0]),
      .stat(evt_stat),
      .mask(evt_mask),
      .irq(irq)
   );

   // read mux, unmapped and unimplemented bits read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      case (req.addr)
         `RCFL_OFS_FLAGS0: rd_val = {24'h000000, flags0_reg};
         `RCFL_OFS_FLAGS1: rd_val = {24'h000000, flags1_reg};
         `RCFL_OFS_STATUS: rd_val = {30'h0, timeout_status_bit, powerdown_status_bit};
         `RCFL_OFS_EVT_STAT: rd_val = {{(32 - EVT_W){1'b0}}, evt_stat};
         `RCFL_OFS_EVT_MASK: rd_val = {{(32 - EVT_W){1'b0}}, evt_mask};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // cause decode
   // ----------------------------------------------------------------
   // one cause per cycle, highest priority first
   always_comb begin
      if (evt.brownout) begin
         cause = RCFL_C_BROWN;
      end else if (evt.mem_viol) begin
         cause = RCFL_C_MEMORY_VIOLATION_FLAG;
      end else if (evt.ext_reset) begin
         cause = asleep ? RCFL_C_EXT_SLP : RCFL_C_EXT;
      end else if (evt.wdt_timeout) begin
         cause = RCFL_C_WDT_TO;
      end else if (evt.wdt_window) begin
         cause = RCFL_C_WDT_WV;
      end else if (evt.reset_instr) begin
         cause = RCFL_C_RSTINS;
      end else if (evt.stack_ovf && stack_reset_enable) begin
         cause = RCFL_C_OVF;
      end else if (evt.stack_unf && stack_reset_enable) begin
         cause = RCFL_C_UNF;
      end else if (evt.wdt_wake && asleep) begin
         cause = RCFL_C_WDT_WAKE;
      end else if (evt.irq_wake && asleep) begin
         cause = RCFL_C_IRQ_WAKE;
      end else begin
         cause = RCFL_C_NONE;
      end
   end

   assign is_wake = (cause == RCFL_C_WDT_WAKE) || (cause == RCFL_C_IRQ_WAKE);
   assign is_reset = (cause != RCFL_C_NONE) && !is_wake;

   // ----------------------------------------------------------------
   // cause flags
   // ----------------------------------------------------------------
   // first flag register, hardware update wins over a software write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags0_reg <= `RCFL_FLAGS0_POR;
      end else begin
         case (cause)
            RCFL_C_BROWN: flags0_reg <= {6'b001111, flags0_reg[1], 1'b0};
            RCFL_C_EXT, RCFL_C_EXT_SLP: flags0_reg[`RCFL_B_EXTRST] <= 1'b0;
            RCFL_C_WDT_TO: flags0_reg[`RCFL_B_WDTTO] <= 1'b0;
            RCFL_C_WDT_WV: flags0_reg[`RCFL_B_WINVIO] <= 1'b0;
            RCFL_C_RSTINS: flags0_reg[`RCFL_B_RSTINS] <= 1'b0;
            RCFL_C_OVF: flags0_reg[`RCFL_B_STACK_OVERFLOW_FLAG] <= 1'b1;
            RCFL_C_UNF: flags0_reg[`RCFL_B_STACK_UNDERFLOW_FLAG] <= 1'b1;
            default: begin
               // a write that meets any reset or wake is lost, hardware owns that cycle
               if (wr_f0 && !is_reset && !is_wake) begin
                  flags0_reg <= req.wdata[7:0];
               end
            end
         endcase
      end
   end

   // second flag register, only the memory violation bit exists
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         flags1_reg <= `RCFL_FLAGS1_POR;
      end else begin
         case (cause)
            RCFL_C_EXT: flags1_reg[`RCFL_B_MEMVIO] <= 1'b1;
            RCFL_C_MEMORY_VIOLATION_FLAG: flags1_reg[`RCFL_B_MEMVIO] <= 1'b0;
            default: begin
               if (wr_f1 && !is_reset && !is_wake) begin
                  flags1_reg <= req.wdata[7:0] & `RCFL_FLAGS1_MASK;
               end
            end
         endcase
      end
   end

   // timeout and power-down status bits
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timeout_status_bit <= 1'b1;
         powerdown_status_bit <= 1'b1;
      end else begin
         case (cause)
            RCFL_C_BROWN: begin
               timeout_status_bit <= 1'b1;
               powerdown_status_bit <= 1'b1;
            end
            RCFL_C_EXT_SLP, RCFL_C_IRQ_WAKE: begin
               timeout_status_bit <= 1'b1;
               powerdown_status_bit <= 1'b0;
            end
            RCFL_C_WDT_TO: timeout_status_bit <= 1'b0;
            RCFL_C_WDT_WAKE: begin
               timeout_status_bit <= 1'b0;
               powerdown_status_bit <= 1'b0;
            end
            default: timeout_status_bit <= timeout_status_bit;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // processor hold and program counter load
   // ----------------------------------------------------------------
   // flags change at the same edge that raises the hold, so they are
   // final long before the processor runs again
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= RCFL_S_HOLD;
         hold_cnt_reg <= 8'(HOLD_CYC);
         cpu_hold <= 1'b1;
      end else begin
         case (state_reg)
            RCFL_S_HOLD: begin
               if (is_reset) begin
                  hold_cnt_reg <= 8'(HOLD_CYC);
               end else if (hold_cnt_reg > 8'h01) begin
                  hold_cnt_reg <= hold_cnt_reg - 8'h01;
               end else begin
                  state_reg <= RCFL_S_RUN;
                  cpu_hold <= 1'b0;
               end
            end
            RCFL_S_RUN, RCFL_S_WAKE: begin
               if (is_reset) begin
                  state_reg <= RCFL_S_HOLD;
                  hold_cnt_reg <= 8'(HOLD_CYC);
                  cpu_hold <= 1'b1;
               end else if (cause == RCFL_C_IRQ_WAKE && global_irq_enable) begin
                  state_reg <= RCFL_S_WAKE;
               end else if (state_reg == RCFL_S_WAKE && instr_done) begin
                  state_reg <= RCFL_S_RUN;
               end
            end
            default: begin
               state_reg <= RCFL_S_HOLD;
               cpu_hold <= 1'b1;
            end
         endcase
      end
   end

   // program counter load pulses and the return-address push
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_load <= 1'b0;
         pc_load_value <= '0;
         ret_push <= 1'b0;
         ret_addr <= '0;
      end else begin
         pc_load <= 1'b0;
         ret_push <= 1'b0;
         if (is_reset) begin
            pc_load <= 1'b1;
            pc_load_value <= PC_W'(`RCFL_VEC_RESET);
         end else if (is_wake) begin
            pc_load <= 1'b1;
            pc_load_value <= pc_now + PC_W'(1);
            ret_addr <= pc_now + PC_W'(2);
         end else if (state_reg == RCFL_S_WAKE && instr_done) begin
            pc_load <= 1'b1;
            pc_load_value <= PC_W'(`RCFL_VEC_IRQ);
            ret_push <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   AST_EXT_AWAKE: assert property (cause == RCFL_C_EXT |=>
      !flags0_reg[3] && flags1_reg[1] && pc_load && pc_load_value == '0)
      else $error("pin reset awake wrong");
   AST_EXT_SLEEP: assert property (cause == RCFL_C_EXT_SLP |=>
      timeout_status_bit && !powerdown_status_bit && !flags0_reg[3])
      else $error("pin reset asleep wrong");
   AST_WDT_WAKE: assert property (cause == RCFL_C_WDT_WAKE |=>
      !timeout_status_bit && !powerdown_status_bit
      && pc_load_value == $past(pc_now) + PC_W'(1) && $stable(flags0_reg))
      else $error("watchdog wake wrong");
   AST_IRQ_WAKE: assert property (cause == RCFL_C_IRQ_WAKE |=>
      timeout_status_bit && !powerdown_status_bit && $stable(flags1_reg))
      else $error("irq wake wrong");
   AST_VECTOR: assert property (state_reg == RCFL_S_WAKE && instr_done && !is_reset
      |=> ret_push && pc_load && pc_load_value == PC_W'(4))
      else $error("vector jump missing");
   AST_OVF: assert property (cause == RCFL_C_OVF |=> flags0_reg[7]
      && flags0_reg[6:0] == $past(flags0_reg[6:0]))
      else $error("overflow flag wrong");
   AST_UNF: assert property (cause == RCFL_C_UNF |=> flags0_reg[6])
      else $error("underflow flag wrong");
   AST_STK_GATE: assert property (!stack_reset_enable && cause != RCFL_C_NONE
      |-> cause != RCFL_C_OVF && cause != RCFL_C_UNF)
      else $error("stack reset without enable");
   AST_SW_NO_RST: assert property (wr_f0 && cause == RCFL_C_NONE && !cpu_hold
      |=> flags0_reg == $past(req.wdata[7:0]) && !cpu_hold)
      else $error("software write misbehaved");
   AST_WDT_TO: assert property (cause == RCFL_C_WDT_TO |=> !flags0_reg[4])
      else $error("timeout flag not cleared");
   AST_WINVIO: assert property (cause == RCFL_C_WDT_WV |=> !flags0_reg[5])
      else $error("window flag not cleared");
   AST_RSTINS: assert property (cause == RCFL_C_RSTINS |=> !flags0_reg[2])
      else $error("instruction flag not cleared");
   AST_MEMORY_VIOLATION_FLAG: assert property (cause == RCFL_C_MEMORY_VIOLATION_FLAG |=> !flags1_reg[1]
      && $stable(flags0_reg))
      else $error("memory flag wrong");
   AST_UNIMPL: assert property (flags1_reg[7:2] == 6'h00 && !flags1_reg[0])
      else $error("unimplemented bit set");
   AST_HOLD: assert property (is_reset |=> cpu_hold [*2])
      else $error("hold too short");
   AST_BROWN: assert property (cause == RCFL_C_BROWN |=> !flags0_reg[0])
      else $error("brown-out flag wrong");

   COV_BROWN: cover property (cause == RCFL_C_BROWN ##[1:10] !cpu_hold);
   COV_VECTOR: cover property (cause == RCFL_C_IRQ_WAKE ##[1:20] ret_push);
   COV_SWFORCE: cover property (wr_f0 && req.wdata[7]);
   COV_IRQ: cover property (irq);
endmodule

//--- rcfl_tb.sv
`include "rcfl_map.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
   $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rcfl_pkg::*;
   // ----------------------------------------------------------------
   // signals and table
   // ----------------------------------------------------------------
   typedef struct {
      logic [9:0] ev;
      logic slp;
      logic stk;
      logic [7:0] pre0;
      logic [7:0] pre1;
      logic [7:0] e0;
      logic [7:0] e1;
      logic [1:0] st;
      logic ld;
      logic [15:0] pc;
   } rcfl_row_t;
   logic clk, arst_n, hsel, hwrite, asleep, stack_reset_enable, global_irq_enable, instr_done;
   logic [31:0] haddr, hwdata, hrdata, rd_v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, cpu_hold, pc_load, ret_push, timeout_status_bit;
   logic powerdown_status_bit, irq;
   logic [15:0] pc_now, pc_load_value, ret_addr, last_pc, last_ret;
   rcfl_evt_t evt;
   wire logic hready;
   int failures, comparisons, n_ld, n_push, n0, p0;
   rcfl_row_t rows[14] = '{
      '{10'h100, 1'b0, 1'b0, 8'h3C, 8'h00, 8'h34, 8'h02, 2'h3, 1'b1, 16'h0000},
      '{10'h100, 1'b1, 1'b0, 8'h3C, 8'h02, 8'h34, 8'h02, 2'h2, 1'b1, 16'h0000},
      '{10'h080, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h2C, 8'h02, 2'h0, 1'b1, 16'h0000},
      '{10'h002, 1'b1, 1'b0, 8'h3C, 8'h02, 8'h3C, 8'h02, 2'h0, 1'b1, 16'h0124},
      '{10'h001, 1'b1, 1'b0, 8'h3C, 8'h02, 8'h3C, 8'h02, 2'h2, 1'b1, 16'h0124},
      '{10'h040, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h1C, 8'h02, 2'h2, 1'b1, 16'h0000},
      '{10'h020, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h38, 8'h02, 2'h2, 1'b1, 16'h0000},
      '{10'h010, 1'b0, 1'b1, 8'h3C, 8'h02, 8'hBC, 8'h02, 2'h2, 1'b1, 16'h0000},
      '{10'h008, 1'b0, 1'b1, 8'h3C, 8'h02, 8'h7C, 8'h02, 2'h2, 1'b1, 16'h0000},
      '{10'h010, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h3C, 8'h02, 2'h2, 1'b0, 16'h0000},
      '{10'h002, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h3C, 8'h02, 2'h2, 1'b0, 16'h0000},
      '{10'h004, 1'b0, 1'b0, 8'h3C, 8'h02, 8'h3C, 8'h00, 2'h2, 1'b1, 16'h0000},
      '{10'h200, 1'b0, 1'b0, 8'hC3, 8'h02, 8'h3E, 8'h02, 2'h3, 1'b1, 16'h0000},
      '{10'h180, 1'b0, 1'b0, 8'h3C, 8'h00, 8'h34, 8'h02, 2'h3, 1'b1, 16'h0000}
   };
   assign hready = hreadyout;

   rcfl_top u_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .asleep(asleep),
      .stack_reset_enable(stack_reset_enable), .global_irq_enable(global_irq_enable),
      .pc_now(pc_now), .instr_done(instr_done), .cpu_hold(cpu_hold), .pc_load(pc_load),
      .pc_load_value(pc_load_value), .ret_push(ret_push), .ret_addr(ret_addr),
      .timeout_status_bit(timeout_status_bit), .powerdown_status_bit(powerdown_status_bit),
      .irq(irq));

   // ----------------------------------------------------------------
   // clock, watchdog, monitors
   // ----------------------------------------------------------------
   // clock generator
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard
   initial begin
      #2000000;
      failures++;
      end_of_test();
   end
   // capture program counter loads and return pushes
   always @(posedge clk) begin
      if (pc_load === 1'b1) begin
         n_ld++;
         last_pc = pc_load_value;
      end
      if (ret_push === 1'b1) begin
         n_push++;
         last_ret = ret_addr;
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      if (failures == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one single word transfer, address phase then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd_v = hrdata;
   endtask
   // one-cycle source pulse, then let the hold run out
   task automatic pulse(input logic [9:0] e);
      @(posedge clk);
      evt <= rcfl_evt_t'(e);
      @(posedge clk);
      evt <= rcfl_evt_t'(10'h000);
      repeat (6) @(posedge clk);
   endtask
   // reset and check power-on values
   task automatic do_reset();
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      ahb(1'b0, `RCFL_OFS_FLAGS0, 32'h0);
      `CHK(rd_v, 32'h0000003C)
      ahb(1'b0, `RCFL_OFS_FLAGS1, 32'h0);
      `CHK(rd_v, 32'h00000002)
      ahb(1'b0, `RCFL_OFS_STATUS, 32'h0);
      `CHK(rd_v, 32'h00000003)
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      {hsel, hwrite, asleep, stack_reset_enable, global_irq_enable, instr_done} = '0;
      {haddr, hwdata, htrans, hsize} = '0;
      evt = rcfl_evt_t'(10'h000);
      pc_now = 16'h0123;
      @(posedge clk);
      do_reset();
      foreach (rows[i]) begin
         asleep <= rows[i].slp;
         stack_reset_enable <= rows[i].stk;
         ahb(1'b1, `RCFL_OFS_FLAGS0, {24'h0, rows[i].pre0});
         ahb(1'b1, `RCFL_OFS_FLAGS1, {24'h0, rows[i].pre1});
         n0 = n_ld;
         pulse(rows[i].ev);
         `CHK(n_ld - n0, int'(rows[i].ld))
         if (rows[i].ld)
            `CHK(last_pc, rows[i].pc)
         ahb(1'b0, `RCFL_OFS_FLAGS0, 32'h0);
         `CHK(rd_v[7:0], rows[i].e0)
         ahb(1'b0, `RCFL_OFS_FLAGS1, 32'h0);
         `CHK(rd_v[7:0], rows[i].e1)
         ahb(1'b0, `RCFL_OFS_STATUS, 32'h0);
         `CHK(rd_v[1:0], rows[i].st)
         `CHK({timeout_status_bit, powerdown_status_bit}, rows[i].st)
      end
      // software forces every flag active; no reset follows
      n0 = n_ld;
      ahb(1'b1, `RCFL_OFS_FLAGS0, 32'h000000C0);
      ahb(1'b1, `RCFL_OFS_FLAGS1, 32'hFFFFFFFD);
      repeat (4) @(posedge clk);
      `CHK(n_ld - n0, 0)
      `CHK(cpu_hold, 1'b0)
      ahb(1'b0, `RCFL_OFS_FLAGS0, 32'h0);
      `CHK(rd_v, 32'h000000C0)
      ahb(1'b0, `RCFL_OFS_FLAGS1, 32'h0);
      `CHK(rd_v, 32'h00000000)
      ahb(1'b1, 8'h14, 32'hFFFFFFFF);
      ahb(1'b0, 8'h14, 32'h0);
      `CHK(rd_v, 32'h00000000)
      `CHK(hresp, 1'b0)
      // interrupt wake with interrupts enabled: next instruction then vector
      asleep <= 1'b1;
      global_irq_enable <= 1'b1;
      n0 = n_ld;
      p0 = n_push;
      pulse(10'h001);
      `CHK(last_pc, 16'h0124)
      asleep <= 1'b0;
      instr_done <= 1'b1;
      @(posedge clk);
      instr_done <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK(n_push - p0, 1)
      `CHK(last_ret, 16'h0125)
      `CHK(last_pc, 16'h0004)
      `CHK(n_ld - n0, 2)
      global_irq_enable <= 1'b0;
      // event status, mask and interrupt line
      ahb(1'b1, `RCFL_OFS_EVT_STAT, 32'h000003FF);
      ahb(1'b1, `RCFL_OFS_EVT_MASK, 32'h00000000);
      pulse(10'h020);
      `CHK(irq, 1'b0)
      ahb(1'b0, `RCFL_OFS_EVT_STAT, 32'h0);
      `CHK(rd_v, 32'h00000020)
      ahb(1'b1, `RCFL_OFS_EVT_MASK, 32'h000003FF);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      ahb(1'b1, `RCFL_OFS_EVT_STAT, 32'h00000020);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      // second reset in mid-run restores power-on values
      do_reset();
      end_of_test();
   end
endmodule
